// >>> bench/add_variants_props.sv
`timescale 1ns/1ps
// Port-level checks on the add datapath
module add_variants_props (
  input wire logic sys_clk_i, // Core clock
  input wire logic nrst_i, // Reset, active low
  input wire add_variants_pkg::add_req_s req_i, // Decoded add
  input wire logic [31:0] status_word_i, // Status word
  input wire logic ovf_clr_i, // Overflow clear
  input wire logic [3:0] data_rd_sel_i, // Data read select
  input wire add_variants_pkg::rd_data_s rd_o, // Read back
  input wire logic done_o, // Done pulse
  input wire logic data_overflow_o // Overflow flag
);
  import add_variants_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic tag_hit, halves_hit, sat_hit, nc_req;
  // Data writes that land on the register being read back
  assign nc_req = req_i.valid && req_i.op == OP_ADD_NO_CARRY;
  assign tag_hit = {req_i.hi_pfx, req_i.dst[2:0]} == data_rd_sel_i;
  assign halves_hit = tag_hit && req_i.valid && req_i.op == OP_ADD_HALVES;
  assign sat_hit = tag_hit && nc_req && status_word_i[SR_SAT_BIT];
  a_done_next: assert property (req_i.valid |=> done_o)
    else $error("done missing");
  a_done_only: assert property (!req_i.valid |=> !done_o)
    else $error("stray done");
  a_reset_idle: assert property (
    $rose(nrst_i) |-> !done_o && !data_overflow_o && rd_o == '0)
    else $error("not idle after reset");
  a_halves_tag: assert property (
    halves_hit ##1 $stable(data_rd_sel_i) |=> !rd_o.limit_tag)
    else $error("tag kept by halves add");
  a_sat_tag: assert property (
    sat_hit ##1 $stable(data_rd_sel_i) |=> !rd_o.limit_tag)
    else $error("tag kept under saturation");
  a_ovf_cause: assert property (
    $rose(data_overflow_o) |-> $past(nc_req))
    else $error("overflow without no-carry add");
  a_ovf_sticky: assert property (
    data_overflow_o && !ovf_clr_i |=> data_overflow_o)
    else $error("overflow lost");
  a_ovf_clear: assert property (
    ovf_clr_i && !nc_req |=> !data_overflow_o)
    else $error("overflow not cleared");
endmodule : add_variants_props

// >>> bench/core_issue_model.sv
`timescale 1ns/1ps
// Decoder side: one decoded add per edge, level held
module core_issue_model (
  input wire logic sys_clk_i, // Core clock
  output add_variants_pkg::add_req_s req_o // Request to the datapath
);
  import add_variants_pkg::*;
  initial req_o = '0;
  // Drive just after an edge; back-to-back calls give one add a cycle
  task automatic send(input add_req_s r);
    @(posedge sys_clk_i);
    #1 req_o <= r;
  endtask : send
  // Drop valid once the last add has been taken
  task automatic idle();
    @(posedge sys_clk_i);
    #1 req_o.valid <= 1'b0;
  endtask : idle
endmodule : core_issue_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// Bench for the add datapath
module tb_top;
  import add_variants_pkg::*;
  typedef struct {
    add_op_e op;
    logic [3:0] d, s;
    logic p;
    logic [15:0] im;
    logic [3:0] sw;
    logic [3:0] rs;
    logic [40:0] ex;
  } row_s;
  logic sys_clk, nrst, ovf_clr, done, ovf;
  logic [3:0] sel;
  logic [31:0] sw, mctl;
  mod_set_t mods;
  add_req_s req;
  rd_data_s rd;
  int num_errors = 0;
  int n_checks = 0;
  // Field sw is {exception stack, scale[1:0], saturation}
  row_s rows [24] = '{
    '{OP_ADDR_U5,4'h8,4'h8,1'b0,16'h001f,4'h0,4'h0,41'h1f},
    '{OP_ADDR_U5,4'h8,4'h8,1'b0,16'hffe1,4'h0,4'h0,41'h20},
    '{OP_ADDR_S16,4'h1,4'h8,1'b0,16'hfff0,4'h0,4'h1,41'h10},
    '{OP_ADDR_REG,4'h9,4'h8,1'b0,16'h0,4'h0,4'h1,41'h30},
    '{OP_SHIFT1_ADDR_ADD,4'h9,4'h8,1'b0,16'h0,4'h0,4'h1,41'h70},
    '{OP_SHIFT2_ADDR_ADD,4'h8,4'h9,1'b0,16'h0,4'h0,4'h0,41'h1e0},
    '{OP_ADDR_REG,4'h9,4'h6,1'b0,16'h0,4'h0,4'h1,41'h1070},
    '{OP_ADDR_S16,4'h1,4'h0,1'b1,16'h7fff,4'h0,4'h9,41'h7fff},
    '{OP_ADDR_S16,4'h2,4'h0,1'b1,16'h8000,4'h0,4'ha,41'hffff8000},
    '{OP_SHIFT2_ADDR_ADD,4'ha,4'ha,1'b1,16'h0,4'h0,4'ha,
      41'hfffd8000},
    '{OP_ADDR_U5,4'h7,4'h7,1'b0,16'h000d,4'h0,4'h3,41'h0},
    '{OP_ADDR_U5,4'h7,4'h7,1'b0,16'h0018,4'h8,4'h3,41'h0},
    '{OP_ADDR_REG,4'hb,4'h7,1'b0,16'h0,4'h0,4'h3,41'h8},
    '{OP_ADDR_REG,4'hc,4'h7,1'b0,16'h0,4'h8,4'h4,41'h18},
    '{OP_ADD_NO_CARRY,4'h2,4'h0,1'b0,16'hca3e,4'h0,4'h2,
      41'hffffffca3e},
    '{OP_ADD_NO_CARRY,4'h2,4'h2,1'b0,16'hca3e,4'h0,4'h2,
      41'hffffff947c},
    '{OP_ADD_HALVES,4'h3,4'h2,1'b0,16'h0,4'h1,4'h3,41'h00ffff947c},
    '{OP_ADD_HALVES,4'h3,4'h2,1'b0,16'h0,4'h0,4'h3,41'h00fffe28f8},
    '{OP_ADD_NO_CARRY,4'h4,4'h3,1'b0,16'h0,4'h0,4'h4,
      41'h100fffe28f8},
    '{OP_ADD_NO_CARRY,4'h5,4'h3,1'b0,16'h0,4'h2,4'h5,41'h00fffe28f8},
    '{OP_ADD_NO_CARRY,4'h5,4'h3,1'b0,16'h0,4'h4,4'h5,
      41'h100fffe28f8},
    '{OP_ADD_HALVES,4'h4,4'h0,1'b0,16'h0,4'h0,4'h4,41'h00fffe28f8},
    '{OP_ADD_NO_CARRY,4'h6,4'h3,1'b0,16'h0,4'h1,4'h6,41'h007fffffff},
    '{OP_ADD_NO_CARRY,4'h2,4'h2,1'b1,16'h0001,4'h0,4'ha,41'h1}
  };
  core_issue_model u_core (.sys_clk_i(sys_clk), .req_o(req));
  add_variants_datapath u_dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .req_i(req), .status_word_i(sw),
    .addr_modifier_bits_i(mctl), .modulus_i(mods), .pc_i(32'h00001000),
    .ovf_clr_i(ovf_clr), .data_rd_sel_i(sel), .addr_rd_sel_i(sel),
    .rd_o(rd), .done_o(done), .data_overflow_o(ovf));
  // Core clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [40:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // One add, then read back the register named by rs two edges later
  task automatic do_op(input row_s r);
    logic isd;
    logic [40:0] got;
    isd = r.op == OP_ADD_HALVES || r.op == OP_ADD_NO_CARRY;
    u_core.send('{1'b1, r.op, r.d, r.s, r.p, r.im});
    sw = {13'h0, r.sw[3], 12'h0, r.sw[2:1], 1'b0, r.sw[0], 2'h0};
    sel = r.rs;
    u_core.idle();
    check("done", {40'h0, done}, 41'h1);
    @(posedge sys_clk);
    #1 got = isd ? {rd.limit_tag, rd.data} : {9'h0, rd.addr};
    check("rd", got, r.ex);
  endtask : do_op
  // Cut a hang short
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    ovf_clr = 1'b0;
    sel = 4'h0;
    sw = 32'h0;
    mctl = 32'h0;
    mods = '0;
    mods[5] = 32'h00000010;
    repeat (20) @(posedge sys_clk);
    #1 nrst = 1'b1;
    foreach (rows[i]) do_op(rows[i]);
    check("ovf", {40'h0, ovf}, 41'h1);
    ovf_clr = 1'b1;
    @(posedge sys_clk);
    #1 ovf_clr = 1'b0;
    check("ovf", {40'h0, ovf}, 41'h0);
    mctl = 32'h00800000;
    do_op('{OP_ADDR_U5,4'hd,4'hd,1'b0,16'h001f,4'h0,4'h5,41'hf});
    do_op('{OP_ADDR_U5,4'hd,4'hd,1'b1,16'h001f,4'h0,4'hd,41'h1f});
    mctl = 32'h0;
    sel = 4'h6;
    u_core.send('{1'b1, OP_ADDR_U5, 4'he, 4'he, 1'b0, 16'h0001});
    u_core.send('{1'b1, OP_ADDR_U5, 4'he, 4'he, 1'b0, 16'h0002});
    u_core.idle();
    @(posedge sys_clk);
    #1 check("rd", {9'h0, rd.addr}, 41'h3);
    // Writes to 0110 and 0100 are dropped but still complete
    do_op('{OP_ADDR_U5,4'h6,4'h6,1'b0,16'h0001,4'h0,4'h6,41'h3});
    do_op('{OP_ADDR_REG,4'h4,4'h8,1'b0,16'h0,4'h0,4'h4,41'h18});
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 check("rst", {rd.data, done}, 41'h0);
    nrst = 1'b1;
    do_op('{OP_ADDR_U5,4'h8,4'h8,1'b0,16'h0001,4'h0,4'h0,41'h1});
    end_sim();
  end
endmodule : tb_top
bind add_variants_datapath add_variants_props u_props (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i),
  .status_word_i(status_word_i), .ovf_clr_i(ovf_clr_i),
  .data_rd_sel_i(data_rd_sel_i), .rd_o(rd_o), .done_o(done_o),
  .data_overflow_o(data_overflow_o));

// >>> pkg/add_variants_pkg.sv
package add_variants_pkg;

  // Datapath widths
  localparam int DATA_W = 40;
  localparam int ADDR_W = 32;
  localparam int HALF_W = 16;
  localparam int U5_W = 5;
  localparam int NUM_DREG = 16;
  localparam int NUM_AREG = 16;
  localparam int NUM_OFFS = 4;
  localparam int NUM_MODREG = 8;
  localparam int AM_W = 4;

  // Status and exception word bit positions
  localparam int SR_SAT_BIT = 2;
  localparam int SR_SCALE_LO = 4;
  localparam int SR_STACK_BIT = 18;
  localparam int EMR_OVF_BIT = 3;

  // Stack pointer writes clear this many low bits
  localparam int SP_ALIGN_BITS = 3;

  // Address selector codes
  localparam logic [3:0] SEL_PC = 4'h6;
  localparam logic [3:0] SEL_SP = 4'h7;
  localparam logic [3:0] SEL_OFFS_MAX = 4'h3;

  // Modifier mode nibble for plain arithmetic
  localparam logic [3:0] AM_LINEAR = 4'h0;

  // Scaling codes for the limit tag window
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;

  // Saturation limits and reset values
  localparam logic [39:0] SAT_POS = 40'h007fffffff;
  localparam logic [39:0] SAT_NEG = 40'hff80000000;
  localparam logic [39:0] DREG_RST = 40'h0000000000;
  localparam logic [31:0] AREG_RST = 32'h00000000;

  typedef enum logic [2:0] {
    OP_ADD_HALVES,
    OP_ADDR_U5,
    OP_ADDR_S16,
    OP_ADDR_REG,
    OP_SHIFT1_ADDR_ADD,
    OP_SHIFT2_ADDR_ADD,
    OP_ADD_NO_CARRY
  } add_op_e;

  typedef struct packed {
    logic valid;
    add_op_e op;
    logic [3:0] dst;
    logic [3:0] src;
    logic hi_pfx;
    logic [15:0] imm;
  } add_req_s;

  typedef struct packed {
    logic [39:0] data;
    logic limit_tag;
    logic [31:0] addr;
  } rd_data_s;

  typedef logic [7:0][31:0] mod_set_t;

endpackage : add_variants_pkg

// >>> src/add_variants_datapath.sv
`timescale 1ns/1ps
// How it works
// - Dual halfword add: carry from bit 15 into 16 suppressed.
// - Dual halfword add leaves extension byte undefined; here it reads zero.
// - Dual halfword add clears the limit tag, ignores status bits.
// - Short address add takes a 5-bit unsigned immediate, 0 to 31.
// - That immediate is zero-extended to 32 bits before adding.
// - Three-operand address add sign-extends 16-bit immediate to 32 bits.
// - Stack pointer destination gets its three low bits forced to zero.
// - Low eight address registers use their modifier mode; others plain.
// - Status bit 18 picks normal or exception stack pointer.
// - Source selector: offsets 0-3, PC at 0110, SP 0111, R0-R7 above.
// - Destination selector same, but 0110 selects nothing.
// - 3-bit address field picks R0-R7; prefix extends to R8-R15.
// - 3-bit data fields pick D0-D7; prefix extends to D8-D15.
// - Shift-by-one add: (src << 1) + second, written to second.
// - Shift-by-two add: (src << 2) + second, written to second.
// - No-carry add: sign-extend 16-bit immediate to 40 bits and add.
// - No-carry add never touches the carry flag.
// - No-carry add sets data overflow on 40-bit overflow or 32-bit saturation.
// - Status bit 2 selects 32-bit saturation for the no-carry add.
// - Limit tag computed when saturation off, cleared when on.
// - Scaling bits 5:4 choose the bits examined for the limit tag.
module add_variants_datapath (
  input wire logic sys_clk_i, // Core clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire add_variants_pkg::add_req_s req_i, // Decoded instruction
  input wire logic [31:0] status_word_i, // Status word
  input wire logic [31:0] addr_modifier_bits_i, // Modifier control word
  input wire add_variants_pkg::mod_set_t modulus_i, // Modulus per R0-R7
  input wire logic [31:0] pc_i, // Program counter value
  input wire logic ovf_clr_i, // Clears the data overflow flag
  input wire logic [3:0] data_rd_sel_i, // Data register to read back
  input wire logic [3:0] addr_rd_sel_i, // Address register to read back
  output add_variants_pkg::rd_data_s rd_o, // Registered read back
  output logic done_o, // One-cycle pulse per executed add
  output logic data_overflow_o // Overflow bit of exception_mode_word
);
  import add_variants_pkg::*;

  // Register files and flags
  logic [DATA_W-1:0] result_reg [NUM_DREG];
  logic limit_tag [NUM_DREG];
  logic [ADDR_W-1:0] addr_target [NUM_AREG];
  logic [ADDR_W-1:0] offs_reg [NUM_OFFS];
  logic [ADDR_W-1:0] sp_norm_r;
  logic [ADDR_W-1:0] sp_exc_r;
  logic data_overflow_r;

  // Decoded fields and operands
  logic [3:0] d_dst;
  logic [3:0] d_src;
  logic [DATA_W-1:0] first_operand_reg;
  logic [DATA_W-1:0] second_val;
  logic stack_sel;
  logic sat_on;
  logic [1:0] scale;

  // Data unit results
  logic [DATA_W-1:0] d_res;
  logic d_tag;
  logic d_ovf;
  logic d_we;
  logic [DATA_W:0] nc_sum;
  logic [DATA_W-1:0] nc_val;
  logic out32;
  logic tag_raw;
  logic [DATA_W-1:0] nc_sat;

  // Address unit results
  logic [ADDR_W-1:0] a_src;
  logic [ADDR_W-1:0] a_dst;
  logic [ADDR_W-1:0] a_lhs;
  logic [ADDR_W-1:0] a_rhs;
  logic [ADDR_W-1:0] a_sum;
  logic [ADDR_W-1:0] a_old;
  logic [ADDR_W-1:0] a_mask;
  logic [ADDR_W-1:0] a_res;
  logic [3:0] a_wsel;
  logic [3:0] a_msel;
  logic a_op;
  logic [AM_W-1:0] am_mode;
  logic mod_on;
  logic [ADDR_W-1:0] sp_wr;

  // Read an address-unit register by 4-bit selector and prefix
  function automatic logic [ADDR_W-1:0] agu_read(input logic [3:0] sel,
                                                 input logic hi);
    logic [ADDR_W-1:0] v;
    // Codes 0100 and 0101 name no register and read as zero
    v = '0;
    if (sel[3]) begin
      v = addr_target[{hi, sel[2:0]}];
    end else if (sel <= SEL_OFFS_MAX) begin
      v = offs_reg[sel[1:0]];
    end else if (sel == SEL_PC) begin
      v = pc_i;
    end else if (sel == SEL_SP) begin
      v = stack_sel ? sp_exc_r : sp_norm_r;
    end
    return v;
  endfunction : agu_read

  // Status fields; no other status bit is consulted
  assign stack_sel = status_word_i[SR_STACK_BIT];
  assign sat_on = status_word_i[SR_SAT_BIT];
  assign scale = status_word_i[SR_SCALE_LO +: 2];

  // Data register fields with prefix extension
  assign d_dst = {req_i.hi_pfx, req_i.dst[2:0]};
  assign d_src = {req_i.hi_pfx, req_i.src[2:0]};
  assign first_operand_reg = result_reg[d_src];
  assign second_val = result_reg[d_dst];

  // No-carry add: sign-extended immediate over 40 bits, one spare bit
  assign nc_sum = {first_operand_reg[DATA_W-1], first_operand_reg} +
                  {{(DATA_W-HALF_W+1){req_i.imm[HALF_W-1]}},
                   req_i.imm};
  assign nc_val = nc_sum[DATA_W-1:0];
  assign out32 = ~(&nc_val[39:31]) & (|nc_val[39:31]);

  // Saturate on the true sign, which survives a 40-bit wrap
  assign nc_sat = nc_sum[DATA_W] ? SAT_NEG : SAT_POS;

  // Limit tag window chosen by the scaling bits
  always_comb begin
    case (scale)
      SCALE_DOWN: tag_raw = ~(&nc_val[39:32]) & (|nc_val[39:32]);
      SCALE_UP: tag_raw = ~(&nc_val[39:30]) & (|nc_val[39:30]);
      // Scale 11 shares the unscaled window
      default: tag_raw = out32;
    endcase
  end

  // Data unit result, tag and overflow
  always_comb begin
    d_res = second_val;
    d_tag = 1'b0;
    d_ovf = 1'b0;
    d_we = 1'b0;
    if (req_i.valid) begin
      case (req_i.op)
        OP_ADD_HALVES: begin
          d_we = 1'b1;
          // Extension byte is left zero
          d_res = {8'h00,
                   second_val[31:16] + first_operand_reg[31:16],
                   second_val[15:0] + first_operand_reg[15:0]};
          d_tag = 1'b0;
        end
        OP_ADD_NO_CARRY: begin
          d_we = 1'b1;
          // No carry flag leaves this block, so it cannot change
          d_ovf = nc_sum[DATA_W] ^ nc_sum[DATA_W-1];
          if (sat_on && out32) begin
            d_res = nc_sat;
            d_ovf = 1'b1;
          end else begin
            d_res = nc_val;
          end
          d_tag = sat_on ? 1'b0 : (tag_raw | d_ovf);
        end
        default: begin
          d_we = 1'b0;
        end
      endcase
    end
  end

  // Address unit operand selection
  always_comb begin
    a_src = agu_read(req_i.src, req_i.hi_pfx);
    a_dst = agu_read(req_i.dst, req_i.hi_pfx);
    a_lhs = a_dst;
    a_rhs = a_src;
    a_old = a_dst;
    a_wsel = req_i.dst;
    a_msel = req_i.dst;
    a_op = req_i.valid;
    case (req_i.op)
      OP_ADDR_U5: begin
        a_rhs = {{(ADDR_W-U5_W){1'b0}}, req_i.imm[U5_W-1:0]};
      end
      OP_ADDR_S16: begin
        // Source plus immediate, written to an R register
        a_lhs = a_src;
        a_rhs = {{(ADDR_W-HALF_W){req_i.imm[HALF_W-1]}}, req_i.imm};
        a_old = a_src;
        a_msel = req_i.src;
        a_wsel = {1'b1, req_i.dst[2:0]};
      end
      OP_ADDR_REG: begin
        a_rhs = a_src;
      end
      OP_SHIFT1_ADDR_ADD: begin
        a_rhs = {a_src[ADDR_W-2:0], 1'b0};
      end
      OP_SHIFT2_ADDR_ADD: begin
        a_rhs = {a_src[ADDR_W-3:0], 2'b00};
      end
      default: begin
        a_op = 1'b0;
      end
    endcase
  end

  // Plain sum, then modulo wrap for low registers in a non-linear mode
  assign a_sum = a_lhs + a_rhs;
  assign am_mode = addr_modifier_bits_i[a_msel[2:0]*AM_W +: AM_W];
  assign a_mask = modulus_i[a_msel[2:0]] - 32'h00000001;
  assign mod_on = a_msel[3] && !req_i.hi_pfx && am_mode != AM_LINEAR;

  // Bits above the modulus come from the old pointer value
  always_comb begin
    a_res = a_sum;
    if (mod_on) begin
      a_res = (a_old & ~a_mask) | (a_sum & a_mask);
    end
  end

  // Stack pointer writes keep it a multiple of eight
  assign sp_wr = {a_res[ADDR_W-1:SP_ALIGN_BITS],
                  {SP_ALIGN_BITS{1'b0}}};

  // Data register file; written in the cycle of the request
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_DREG; i++) begin
        result_reg[i] <= DREG_RST;
        limit_tag[i] <= 1'b0;
      end
    end else if (d_we) begin
      result_reg[d_dst] <= d_res;
      limit_tag[d_dst] <= d_tag;
    end
  end

  // Address registers; 0110 and unused codes are not writable
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_AREG; i++) begin
        addr_target[i] <= AREG_RST;
      end
      for (int i = 0; i < NUM_OFFS; i++) begin
        offs_reg[i] <= AREG_RST;
      end
      sp_norm_r <= AREG_RST;
      sp_exc_r <= AREG_RST;
    end else if (a_op) begin
      if (a_wsel[3]) begin
        addr_target[{req_i.hi_pfx, a_wsel[2:0]}] <= a_res;
      end else if (a_wsel <= SEL_OFFS_MAX) begin
        offs_reg[a_wsel[1:0]] <= a_res;
      end else if (a_wsel == SEL_SP) begin
        if (stack_sel) begin
          sp_exc_r <= sp_wr;
        end else begin
          sp_norm_r <= sp_wr;
        end
      end
    end
  end

  // Sticky overflow; a new overflow wins over a clear; carry is never driven
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      data_overflow_r <= 1'b0;
    end else if (d_ovf) begin
      data_overflow_r <= 1'b1;
    end else if (ovf_clr_i) begin
      data_overflow_r <= 1'b0;
    end
  end

  // Flag output comes straight from its flop
  assign data_overflow_o = data_overflow_r;

  // Completion pulse
  // Refused destinations still count as executed
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= d_we | a_op;
    end
  end

  // Registered read back of the register files
  // Reads the arrays as they stood before this edge's write
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_o <= '0;
    end else begin
      rd_o.data <= result_reg[data_rd_sel_i];
      rd_o.limit_tag <= limit_tag[data_rd_sel_i];
      rd_o.addr <= addr_target[addr_rd_sel_i];
    end
  end

endmodule : add_variants_datapath
